/* File: fced_pkg.sv */
// package: register map, command codes, flag layout and limits of the flash command error detector
package fced_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] FCED_CTRL_OFS = 8'h00;
  localparam logic [7:0] FCED_SADDR_OFS = 8'h04;
  localparam logic [7:0] FCED_EADDR_OFS = 8'h08;
  localparam logic [7:0] FCED_CMD_OFS = 8'h0C;
  localparam logic [7:0] FCED_WINDOW_OFS = 8'h10;
  localparam logic [7:0] FCED_STATUS_OFS = 8'h14;
  localparam logic [7:0] FCED_IRQEN_OFS = 8'h18;

  // control register fields
  localparam int FCED_CTRL_MODE_LSB = 0;
  localparam int FCED_CTRL_LARGE_BIT = 2;
  localparam int FCED_CTRL_WLOCK_BIT = 3;
  localparam int FCED_CTRL_PEEN_BIT = 4;
  localparam logic [4:0] FCED_CTRL_RESET = 5'h08;

  // operating modes held in the control register
  localparam logic [1:0] FCED_MODE_READ = 2'h0;
  localparam logic [1:0] FCED_MODE_CODE_PE = 2'h1;
  localparam logic [1:0] FCED_MODE_DATA_PE = 2'h2;

  // command register fields and command codes
  localparam int FCED_CMD_WINSEL_BIT = 8;
  localparam logic [3:0] FCED_OP_PROGRAM = 4'h1;
  localparam logic [3:0] FCED_OP_BLOCK_ERASE = 4'h2;
  localparam logic [3:0] FCED_OP_MULTI_ERASE = 4'h3;
  localparam logic [3:0] FCED_OP_BLANK_CHECK = 4'h4;
  localparam logic [3:0] FCED_OP_CFG_PROGRAM = 4'h5;
  localparam logic [3:0] FCED_OP_CFG_SETTING = 4'h6;
  localparam logic [3:0] FCED_OP_SUSPEND = 4'h7;
  localparam logic [3:0] FCED_OP_RESUME = 4'h8;
  localparam logic [3:0] FCED_OP_RECOVER = 4'h9;

  // address limits of the violation checks
  localparam logic [16:0] FCED_DF_VIOL_LO = 17'h08000;
  localparam logic [16:0] FCED_DF_VIOL_HI = 17'h1FFFF;
  localparam logic [23:0] FCED_CF_LIMIT_LARGE = 24'hDFFFFF;
  localparam logic [23:0] FCED_CF_LIMIT_SMALL = 24'hEFFFFF;
  localparam logic [9:0] FCED_CFG_LOW_HI = 10'h0FF;
  localparam logic [9:0] FCED_CFG_HIGH_LO = 10'h180;
  localparam int FCED_BLK_LSB = 13;
  localparam int FCED_BLK_W = 11;
  localparam int FCED_WIN_END_LSB = 16;

  // status register fields above the ten error flags
  localparam int FCED_ST_LOCK_BIT = 10;
  localparam int FCED_ST_BUSY_BIT = 11;
  localparam int FCED_ST_SUSP_BIT = 12;

  // interrupt enable fields
  localparam int FCED_IE_LOCK_BIT = 0;
  localparam int FCED_IE_DATA_AREA_VIOLATION_FLAG_BIT = 1;
  localparam int FCED_IE_CODE_AREA_VIOLATION_FLAG_BIT = 2;

  // ten error flags, msb first as they sit in the status register
  typedef struct packed {
    logic illegal_command_flag;
    logic entry_setting_error_flag;
    logic security_error_flag;
    logic other_error_flag;
    logic illegal_state_flag;
    logic erase_error_flag;
    logic program_error_flag;
    logic write_enable_error_flag;
    logic code_area_violation_flag;
    logic data_area_violation_flag;
  } fced_flags_type;

  localparam fced_flags_type FCED_FLAGS_RESET = '0;

  // sequencer states
  typedef enum logic [1:0] {FCED_IDLE, FCED_BUSY, FCED_SUSPENDED} fced_state_type;
endpackage : fced_pkg

/* File: fced_detect.sv */
// file: flash command error detection and command lock with a wishbone register slave
`timescale 1ns/10ps
// How it works
// - multi-block erase with start above end or end in data hole: illegal command
// - command not accepted in current mode sets illegal command and illegal state only
// - code mode program or block erase outside access window: illegal command and illegal state
// - program into block whose erase is suspended: illegal command and illegal state
// - command with acceptance conditions unmet sets illegal state, other flags kept
// - erase failure sets only the erase error flag
// - program failure sets only the program error flag, the erase error flag while an erase is suspended
// - code mode program or block erase at or below limit: code violation, illegal state
// - code mode config program in low or upper config hole: code violation
// - data mode program or erase in data hole: data violation, illegal state
// - data mode multi erase or blank check in hole: three flags together
// - window or boot swap setting while window lock bit is 0: security error
// - any command area access in read mode: other error and illegal state
// - command area read in either program/erase mode: other error and illegal state
// - command other than config setting while protect disables programming: write enable error, no illegal state
// - multi erase refused for address order or end in hole also flags data violation on start address
// - command other than recovery while locked in program/erase mode sets illegal state and illegal command, others kept
// - lock during operation lets it run on; later suspend cannot stop it
// - error interrupt when lock, data or code violation flag and its enable set
module fced_detect
  import fced_pkg::*;
#(
  parameter int OP_CYCLES = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // flash core result and sequencer outputs
  input wire logic op_fail_i,
  output logic busy_o,
  output logic err_irq_o
);
  localparam logic [15:0] OP_LAST = 16'(OP_CYCLES - 1);

  // register state
  logic [4:0] ctrl_q, ctrl_d;
  logic [23:0] start_address_reg_q, start_address_reg_d;
  logic [23:0] end_address_reg_q, end_address_reg_d;
  logic [31:0] access_window_reg_q, access_window_reg_d;
  logic [2:0] irq_en_q, irq_en_d;
  fced_flags_type flags_q, flags_d;
  logic command_lock_flag_q, command_lock_flag_d;
  fced_state_type state_q, state_d;
  logic op_erase_q, op_erase_d;
  logic [FCED_BLK_W-1:0] susp_blk_q, susp_blk_d;
  logic [15:0] cnt_q, cnt_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic irq_q, irq_d;
  logic busy_q, busy_d;

  // decoded helpers
  logic acc, wr, rd;
  logic [3:0] op;
  logic [1:0] mode;
  logic [23:0] cf_limit;
  logic [FCED_BLK_W-1:0] blk, win_lo, win_hi;
  logic sa_df, ea_df, pe_cmd, multi_or_bc;
  logic [31:0] wmask;

  // a request is served once; ack drops in the cycle after it was given
  assign acc = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = acc && wb_we_i;
  assign rd = acc && !wb_we_i;
  assign op = wb_dat_i[3:0];
  assign mode = ctrl_q[FCED_CTRL_MODE_LSB +: 2];
  assign cf_limit = ctrl_q[FCED_CTRL_LARGE_BIT] ? FCED_CF_LIMIT_LARGE : FCED_CF_LIMIT_SMALL;
  assign blk = start_address_reg_q[FCED_BLK_LSB +: FCED_BLK_W];
  assign win_lo = access_window_reg_q[0 +: FCED_BLK_W];
  assign win_hi = access_window_reg_q[FCED_WIN_END_LSB +: FCED_BLK_W];
  assign sa_df = start_address_reg_q[16:0] >= FCED_DF_VIOL_LO && start_address_reg_q[16:0] <= FCED_DF_VIOL_HI;
  assign ea_df = end_address_reg_q[16:0] >= FCED_DF_VIOL_LO && end_address_reg_q[16:0] <= FCED_DF_VIOL_HI;
  assign pe_cmd = op == FCED_OP_PROGRAM || op == FCED_OP_BLOCK_ERASE;
  assign multi_or_bc = op == FCED_OP_MULTI_ERASE || op == FCED_OP_BLANK_CHECK;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // next state of registers, flags, lock and sequencer
  always_comb begin
    fced_flags_type ev;
    logic lock_ev;
    logic start_op;
    ev = FCED_FLAGS_RESET;
    lock_ev = 1'b0;
    start_op = 1'b0;
    ctrl_d = ctrl_q;
    start_address_reg_d = start_address_reg_q;
    end_address_reg_d = end_address_reg_q;
    access_window_reg_d = access_window_reg_q;
    irq_en_d = irq_en_q;
    flags_d = flags_q;
    command_lock_flag_d = command_lock_flag_q;
    state_d = state_q;
    op_erase_d = op_erase_q;
    susp_blk_d = susp_blk_q;
    cnt_d = cnt_q;
    ack_d = acc;
    rdat_d = '0;

    // running operation keeps counting even when locked
    if (state_q == FCED_BUSY) begin
      cnt_d = cnt_q + 16'h0001;
      if (cnt_q == OP_LAST) begin
        state_d = FCED_IDLE;
        cnt_d = '0;
        if (op_fail_i && op_erase_q) ev.erase_error_flag = 1'b1;
        if (op_fail_i && !op_erase_q) ev.program_error_flag = 1'b1;
      end
    end

    // plain register writes with byte lanes
    if (wr) begin
      unique case (wb_adr_i)
        FCED_CTRL_OFS: ctrl_d = (ctrl_q & ~wmask[4:0]) | (wb_dat_i[4:0] & wmask[4:0]);
        FCED_SADDR_OFS: start_address_reg_d = (start_address_reg_q & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
        FCED_EADDR_OFS: end_address_reg_d = (end_address_reg_q & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
        FCED_WINDOW_OFS: access_window_reg_d = (access_window_reg_q & ~wmask) | (wb_dat_i & wmask);
        FCED_IRQEN_OFS: irq_en_d = (irq_en_q & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
        default: ;
      endcase
    end

    // reads; unmapped offsets answer zero
    if (rd) begin
      unique case (wb_adr_i)
        FCED_CTRL_OFS: rdat_d = {27'h0000000, ctrl_q};
        FCED_SADDR_OFS: rdat_d = {8'h00, start_address_reg_q};
        FCED_EADDR_OFS: rdat_d = {8'h00, end_address_reg_q};
        FCED_WINDOW_OFS: rdat_d = access_window_reg_q;
        FCED_IRQEN_OFS: rdat_d = {29'h00000000, irq_en_q};
        FCED_STATUS_OFS: rdat_d = {19'h00000, state_q == FCED_SUSPENDED, state_q == FCED_BUSY,
                                   command_lock_flag_q, flags_q};
        default: rdat_d = '0;
      endcase
    end

    // command area access: read and read-mode hazards first
    if (acc && wb_adr_i == FCED_CMD_OFS) begin
      if (mode == FCED_MODE_READ || !wb_we_i) begin
        ev.other_error_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
      end else if (op == FCED_OP_RECOVER) begin
        // recovery clears flags and lock; same-cycle events are added after this
        flags_d = FCED_FLAGS_RESET;
        command_lock_flag_d = 1'b0;
      end else if (command_lock_flag_q) begin
        // a running operation is not touched here, so a suspend cannot stop it
        ev.illegal_command_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
      end else if (op == FCED_OP_SUSPEND) begin
        if (state_q == FCED_BUSY && op_erase_q) begin
          state_d = FCED_SUSPENDED;
          cnt_d = cnt_q;
        end else begin
          ev.illegal_state_flag = 1'b1;
        end
      end else if (op == FCED_OP_RESUME) begin
        if (state_q == FCED_SUSPENDED) state_d = FCED_BUSY;
        else ev.illegal_state_flag = 1'b1;
      end else if (state_q == FCED_BUSY) begin
        ev.illegal_state_flag = 1'b1;
      end else if (op < FCED_OP_PROGRAM || op > FCED_OP_CFG_SETTING
                   || (mode != FCED_MODE_CODE_PE && mode != FCED_MODE_DATA_PE)
                   || (mode == FCED_MODE_CODE_PE && op == FCED_OP_BLANK_CHECK)
                   || (mode == FCED_MODE_DATA_PE && (op == FCED_OP_CFG_PROGRAM || op == FCED_OP_CFG_SETTING))
                   || (state_q == FCED_SUSPENDED && op != FCED_OP_PROGRAM)) begin
        ev.illegal_command_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
      end else if (mode == FCED_MODE_DATA_PE && multi_or_bc && sa_df) begin
        // data hole on a range command: this case outranks the start/end order check
        ev.illegal_command_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
        ev.data_area_violation_flag = 1'b1;
      end else if (op == FCED_OP_MULTI_ERASE
                   && (start_address_reg_q > end_address_reg_q || ea_df)) begin
        ev.illegal_command_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
        ev.data_area_violation_flag = sa_df;
      end else if (mode == FCED_MODE_CODE_PE && pe_cmd && start_address_reg_q <= cf_limit) begin
        // limit depends on the part size bit; the equal case counts as a violation
        ev.code_area_violation_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
      end else if (mode == FCED_MODE_CODE_PE && op == FCED_OP_CFG_PROGRAM
                   && (start_address_reg_q[9:0] <= FCED_CFG_LOW_HI
                       || start_address_reg_q[9:0] >= FCED_CFG_HIGH_LO)) begin
        // only the middle slice of the config page may be programmed
        ev.code_area_violation_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
      end else if (mode == FCED_MODE_DATA_PE && pe_cmd && sa_df) begin
        ev.data_area_violation_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
      end else if (op == FCED_OP_CFG_SETTING && wb_dat_i[FCED_CMD_WINSEL_BIT]
                   && !ctrl_q[FCED_CTRL_WLOCK_BIT]) begin
        // while the window lock bit is clear a window or boot swap setting is refused
        ev.security_error_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
      end else if (mode == FCED_MODE_CODE_PE && pe_cmd && (blk < win_lo || blk > win_hi)) begin
        // window bounds are whole blocks, both ends inclusive
        ev.illegal_command_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
      end else if (state_q == FCED_SUSPENDED && blk == susp_blk_q) begin
        // the suspended block holds half-erased data, so programming it is refused
        ev.illegal_command_flag = 1'b1;
        ev.illegal_state_flag = 1'b1;
      end else if (op != FCED_OP_CFG_SETTING && !ctrl_q[FCED_CTRL_PEEN_BIT]) begin
        // protect register blocks the write; no lock results
        ev.write_enable_error_flag = 1'b1;
      end else begin
        start_op = 1'b1;
      end
    end

    // launch: suspended erase remembers its block while a program runs
    if (start_op) begin
      if (state_q == FCED_IDLE) begin
        susp_blk_d = blk;
        op_erase_d = op != FCED_OP_PROGRAM && op != FCED_OP_CFG_PROGRAM && op != FCED_OP_CFG_SETTING;
      end
      state_d = FCED_BUSY;
      cnt_d = '0;
    end

    // set wins over the recovery clear; other flags keep their values
    lock_ev = ev.illegal_state_flag;
    flags_d = flags_d | ev;
    if (lock_ev) command_lock_flag_d = 1'b1;
  end

  // error interrupt and busy outputs come from flip-flops
  always_comb begin
    irq_d = (command_lock_flag_d && irq_en_d[FCED_IE_LOCK_BIT])
            || (flags_d.data_area_violation_flag && irq_en_d[FCED_IE_DATA_AREA_VIOLATION_FLAG_BIT])
            || (flags_d.code_area_violation_flag && irq_en_d[FCED_IE_CODE_AREA_VIOLATION_FLAG_BIT]);
    busy_d = state_d == FCED_BUSY;
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= FCED_CTRL_RESET;
      start_address_reg_q <= '0;
      end_address_reg_q <= '0;
      access_window_reg_q <= '0;
      irq_en_q <= '0;
      flags_q <= FCED_FLAGS_RESET;
      command_lock_flag_q <= 1'b0;
      state_q <= FCED_IDLE;
      op_erase_q <= 1'b0;
      susp_blk_q <= '0;
      cnt_q <= '0;
      ack_q <= 1'b0;
      rdat_q <= '0;
      irq_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      start_address_reg_q <= start_address_reg_d;
      end_address_reg_q <= end_address_reg_d;
      access_window_reg_q <= access_window_reg_d;
      irq_en_q <= irq_en_d;
      flags_q <= flags_d;
      command_lock_flag_q <= command_lock_flag_d;
      state_q <= state_d;
      op_erase_q <= op_erase_d;
      susp_blk_q <= susp_blk_d;
      cnt_q <= cnt_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      irq_q <= irq_d;
      busy_q <= busy_d;
    end
  end

  // port drive
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign err_irq_o = irq_q;
  assign busy_o = busy_q;
endmodule : fced_detect

/* File: fced_checker.sv */
// checker: bus and sequencer timing properties of the flash command error detector
`timescale 1ns/10ps
module fced_checker
  import fced_pkg::*;
#(
  parameter int OP_CYCLES = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // sequencer
  input wire logic op_fail_i,
  input wire logic busy_o,
  input wire logic err_irq_o
);
  logic [7:0] run_q;
  logic [7:0] run_d;
  // busy run length; saturates so a stuck busy cannot wrap under the bound
  always_comb begin
    run_d = busy_o ? run_q + ((run_q == 8'hFF) ? 8'h00 : 8'h01) : 8'h00;
  end
  always_ff @(posedge clk_i) begin
    run_q <= rst_i ? 8'h00 : run_d;
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in one cycle");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_ack_was_asked: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without request");
  a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data driven outside acknowledge");
  a_busy_bound: assert property (run_q <= OP_CYCLES)
    else $error("operation runs past its length");
  a_busy_from_cmd: assert property ($rose(busy_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i
    && wb_adr_i == FCED_CMD_OFS))
    else $error("operation started without command write");
  a_irq_from_access: assert property ($changed(err_irq_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("error interrupt moved without bus access");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !busy_o && !err_irq_o)
    else $error("outputs active after reset");
endmodule : fced_checker

bind fced_detect fced_checker #(.OP_CYCLES(OP_CYCLES)) u_fced_checker (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .op_fail_i(op_fail_i),
  .busy_o(busy_o),
  .err_irq_o(err_irq_o)
);

/* File: fced_core_model.sv */
// model: flash core that reports a failure at the end of an operation on request
`timescale 1ns/10ps
module fced_core_model (
  // sequencer view
  input wire logic busy_i,
  input wire logic fail_req_i,
  // failure level back to the detector
  output logic op_fail_o
);
  // an idle core reports nothing, so a stale request cannot leak in
  assign op_fail_o = busy_i & fail_req_i;
endmodule : fced_core_model

/* File: fced_detect_tb.sv */
// testbench: issues flash commands over wishbone and checks the error flags
`timescale 1ns/10ps
module fced_detect_tb
  import fced_pkg::*;
;
  localparam logic [12:0] L = 13'h0400, B = 13'h0800, S = 13'h1000, IC = 13'h0200, SE = 13'h0080;
  localparam logic [12:0] OT = 13'h0040, IL = 13'h0020, ER = 13'h0010, PR = 13'h0008;
  localparam logic [12:0] WE = 13'h0004, CV = 13'h0002, DV = 13'h0001;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fail_req = 1'b0, ack, busy, irq, op_fail;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  int error_cnt = 0, cmp_count = 0, cyc_cnt = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  fced_detect #(.OP_CYCLES(16)) u_fced_detect (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .op_fail_i(op_fail), .busy_o(busy), .err_irq_o(irq));
  fced_core_model u_fced_core_model (.busy_i(busy), .fail_req_i(fail_req), .op_fail_o(op_fail));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // a hung handshake ends the run as a failure
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; request held until ack is sampled, released at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // every setup call starts from reset so flags of an earlier scenario never carry over
  task automatic setup(input logic [31:0] ctrl, input logic [31:0] sa, input logic [31:0] ea);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, FCED_CTRL_OFS, ctrl);
    wb(1'b1, FCED_SADDR_OFS, sa);
    wb(1'b1, FCED_EADDR_OFS, ea);
    wb(1'b1, FCED_WINDOW_OFS, 32'h07FF0700);
  endtask : setup
  task automatic st_chk(input logic [12:0] exp);
    wb(1'b0, FCED_STATUS_OFS, 32'h0);
    check(rdat, {19'h0, exp});
  endtask : st_chk
  task automatic cmd_chk(input logic [3:0] op, input logic [12:0] exp);
    wb(1'b1, FCED_CMD_OFS, {28'h0, op});
    st_chk(exp);
  endtask : cmd_chk
  task automatic irq_chk(input logic [31:0] ie, input logic exp);
    wb(1'b1, FCED_IRQEN_OFS, ie);
    check({31'h0, irq}, {31'h0, exp});
  endtask : irq_chk
  task automatic finish_op(input logic [12:0] exp);
    while (busy !== 1'b0) @(posedge clk_i);
    st_chk(exp);
  endtask : finish_op
  task automatic t_read_mode();
    setup(32'h0, 32'h0, 32'h0);
    wb(1'b0, 8'h1C, 32'h0);
    check(rdat, 32'h0);
    cmd_chk(FCED_OP_PROGRAM, L | OT | IL);
    irq_chk(32'h1, 1'b1);
    irq_chk(32'h6, 1'b0);
    wb(1'b1, FCED_CTRL_OFS, 32'h1D);
    cmd_chk(FCED_OP_RECOVER, 13'h0);
    $display("test read_mode done");
  endtask : t_read_mode
  task automatic t_data();
    setup(32'h1A, 32'h08000, 32'h0);
    cmd_chk(FCED_OP_PROGRAM, L | DV | IL);
    cmd_chk(FCED_OP_PROGRAM, L | DV | IL | IC);
    irq_chk(32'h2, 1'b1);
    setup(32'h1A, 32'h1FFFF, 32'h1FFFF);
    cmd_chk(FCED_OP_BLANK_CHECK, L | IC | IL | DV);
    setup(32'h1D, 32'h1FFFF, 32'h0);
    cmd_chk(FCED_OP_MULTI_ERASE, L | IC | IL | DV);
    setup(32'h1A, 32'h100, 32'h80);
    cmd_chk(FCED_OP_MULTI_ERASE, L | IC | IL);
    setup(32'h1A, 32'h0, 32'h08000);
    cmd_chk(FCED_OP_MULTI_ERASE, L | IC | IL);
    $display("test data_mode done");
  endtask : t_data
  task automatic t_code();
    setup(32'h1D, 32'hDFFFFF, 32'h0);
    cmd_chk(FCED_OP_PROGRAM, L | CV | IL);
    irq_chk(32'h4, 1'b1);
    setup(32'h19, 32'hEFFFFF, 32'h0);
    cmd_chk(FCED_OP_BLOCK_ERASE, L | CV | IL);
    setup(32'h19, 32'h0FF, 32'h0);
    cmd_chk(FCED_OP_CFG_PROGRAM, L | CV | IL);
    setup(32'h19, 32'h180, 32'h0);
    cmd_chk(FCED_OP_CFG_PROGRAM, L | CV | IL);
    setup(32'h19, 32'h100, 32'h0);
    cmd_chk(FCED_OP_CFG_PROGRAM, B);
    setup(32'h1D, 32'hE00000, 32'h0);
    wb(1'b1, FCED_WINDOW_OFS, 32'h07FF0780);
    cmd_chk(FCED_OP_PROGRAM, L | IC | IL);
    setup(32'h1D, 32'h0, 32'h0);
    wb(1'b0, FCED_CMD_OFS, 32'h0);
    st_chk(L | OT | IL);
    setup(32'h15, 32'h0, 32'h0);
    wb(1'b1, FCED_CMD_OFS, {23'h0, 1'b1, 4'h0, FCED_OP_CFG_SETTING});
    st_chk(L | SE | IL);
    $display("test code_mode done");
  endtask : t_code
  task automatic t_accept();
    setup(32'h1B, 32'h0, 32'h0);
    cmd_chk(FCED_OP_PROGRAM, L | IC | IL);
    setup(32'h1D, 32'h0, 32'h0);
    cmd_chk(4'hF, L | IC | IL);
    setup(32'h1D, 32'h0, 32'h0);
    cmd_chk(FCED_OP_BLANK_CHECK, L | IC | IL);
    setup(32'h1D, 32'h0, 32'h0);
    cmd_chk(FCED_OP_SUSPEND, L | IL);
    setup(32'h1D, 32'h0, 32'h0);
    cmd_chk(FCED_OP_RESUME, L | IL);
    setup(32'h0D, 32'hE00000, 32'h0);
    cmd_chk(FCED_OP_PROGRAM, WE);
    $display("test acceptance done");
  endtask : t_accept
  task automatic t_ops();
    fail_req <= 1'b1;
    setup(32'h1D, 32'hE00000, 32'h0);
    cmd_chk(FCED_OP_PROGRAM, B);
    finish_op(PR);
    setup(32'h1D, 32'hE00000, 32'h0);
    cmd_chk(FCED_OP_BLOCK_ERASE, B);
    finish_op(ER);
    fail_req <= 1'b0;
    setup(32'h1D, 32'hE00000, 32'h0);
    cmd_chk(FCED_OP_BLOCK_ERASE, B);
    cmd_chk(FCED_OP_SUSPEND, S);
    cmd_chk(FCED_OP_PROGRAM, S | L | IC | IL);
    setup(32'h1D, 32'hE00000, 32'h0);
    wb(1'b1, FCED_CMD_OFS, {28'h0, FCED_OP_BLOCK_ERASE});
    wb(1'b1, FCED_CMD_OFS, {28'h0, FCED_OP_PROGRAM});
    cmd_chk(FCED_OP_SUSPEND, B | L | IC | IL);
    finish_op(L | IC | IL);
    $display("test operations done");
  endtask : t_ops
  initial begin
    t_read_mode();
    t_data();
    t_code();
    t_accept();
    t_ops();
    report_and_stop();
  end
endmodule : fced_detect_tb
